// [hdl/lcd_addr_pkg.sv]
// Functional notes
// - page command loads page 0..8 (code loads any 4-bit value 0..15)
// - page load leaves status D6..D4 unchanged; D7 reads busy
// - column set by upper and lower nibble
// - column advances by one per RAM access
// - auto increment stops at column 83H
// - column increment never touches page
// - D7 busy during processing or reset
// - D6 shows segment direction
// - D5 reads 1 while display off
// - D4 reads 1 during initialisation
// - data write stores byte, then increments
// - data read returns byte, then increments
// - first read after column load is dummy
// - serial interface: no RAM read data
// - direction command uses D0
// - increment follows logical column order
// - command encodings for page, column, direction
// - read/modify/write: reads keep column, end restores
package lcd_addr_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned INIT_TIME_NS = 1000;
   localparam int unsigned INIT_CYCLES = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CMD_TIME_NS = 50;
   localparam int unsigned CMD_CYCLES = (CMD_TIME_NS * CLK_MHZ + 999) / 1000;
   // ==========================================================
   // geometry and reset values
   localparam int unsigned NUM_PAGES = 9;
   localparam int unsigned NUM_COLS = 132;
   localparam logic [7:0] COL_LAST = 8'h83;
   localparam logic [3:0] PAGE_LAST = 4'h8;
   localparam logic [7:0] COL_RST = 8'h00;
   localparam logic [3:0] PAGE_RST = 4'h0;
   localparam logic ADC_RST = 1'b0;
   // ==========================================================
   // command encodings
   localparam logic [3:0] OP_PAGE = 4'hB;
   localparam logic [3:0] OP_COL_HI = 4'h1;
   localparam logic [3:0] OP_COL_LO = 4'h0;
   localparam logic [6:0] OP_ADC = 7'h50;
   localparam logic [7:0] OP_RMW = 8'hE0;
   localparam logic [7:0] OP_END = 8'hEE;
   localparam logic [7:0] OP_RESET = 8'hE2;
   // ==========================================================
   // status bit positions
   localparam int unsigned ST_BUSY = 7;
   localparam int unsigned ST_ADC = 6;
   localparam int unsigned ST_OFF = 5;
   localparam int unsigned ST_INIT = 4;
   // ==========================================================
   // synchronised pin vector positions
   localparam int unsigned PIN_RES = 12;
   localparam int unsigned PIN_A0 = 11;
   localparam int unsigned PIN_RD = 10;
   localparam int unsigned PIN_WR = 9;
   localparam int unsigned PIN_SER = 8;
   localparam logic [12:0] PIN_IDLE = 13'h1E00;

   typedef enum logic [2:0] {
      PH_INIT = 3'b001,
      PH_IDLE = 3'b010,
      PH_BUSY = 3'b100
   } phase_t;

   function automatic logic [7:0] col_inc(input logic [7:0] col);
      col_inc = (col < COL_LAST) ? col + 8'h01 : col;
   endfunction
endpackage

// [hdl/lcd_ram_addressing_commands.sv]
`timescale 1ns/100ps
module lcd_ram_addressing_commands #(
   parameter int unsigned INIT_CYC = lcd_addr_pkg::INIT_CYCLES,
   parameter int unsigned CMD_CYC = lcd_addr_pkg::CMD_CYCLES
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESETN,
   // host bus pins
   input wire logic HW_RESET_PIN_N,
   input wire logic CMD_DATA_SELECT,
   input wire logic RD_N,
   input wire logic WR_N,
   input wire logic SERIAL_SEL,
   input wire logic [7:0] DATA_IN,
   output logic [7:0] DATA_OUT,
   output logic DATA_OE,
   // display side
   input wire logic DISPLAY_OFF,
   output logic SEG_REVERSE,
   output logic [3:0] PAGE_ADDR,
   output logic [7:0] COLUMN_ADDR
);
   import lcd_addr_pkg::*;

   default clocking cb_main @(posedge REF_CLK);
   endclocking
   default disable iff (!RESETN);

   localparam int unsigned RAM_WORDS = NUM_PAGES * NUM_COLS;
   localparam int unsigned AW = $clog2(RAM_WORDS);

   if (INIT_CYC < 1 || INIT_CYC > 65535 || CMD_CYC < 1 ||
       CMD_CYC > 65535) begin
      $error("cycle counts must lie in 1..65535");
   end

   typedef struct packed {
      logic [12:0] pin_s1;
      logic [12:0] pin_s2;
      logic rd_d;
      logic wr_d;
      phase_t phase;
      logic [15:0] cnt;
      logic [3:0] page;
      logic [7:0] col;
      logic [7:0] col_save;
      logic rmw;
      logic adc;
      logic dummy;
      logic [7:0] latch;
      logic [7:0] dout;
      logic oe;
   } ctl_t;

   ctl_t st_r;
   ctl_t st_nxt;
   logic [7:0] ram [RAM_WORDS];

   // ==========================================================
   // decode of synchronised pins
   logic [7:0] bus_byte;
   logic a0;
   logic idle;
   logic rd_fall;
   logic rd_rise;
   logic wr_rise;
   logic cmd_wr;
   logic dat_wr;
   logic dat_rd;
   logic stat_rd;
   logic [7:0] status;
   logic ram_we;
   logic [AW-1:0] wr_idx;
   logic [AW-1:0] rd_idx;
   logic rd_ok;

   function automatic logic [AW-1:0] ram_index(input logic [3:0] pg,
                                               input logic [7:0] cl);
      ram_index = AW'(pg * NUM_COLS + cl);
   endfunction

   function automatic logic in_range(input logic [3:0] pg,
                                     input logic [7:0] cl);
      in_range = (pg <= PAGE_LAST) && (cl <= COL_LAST);
   endfunction

   assign bus_byte = st_r.pin_s2[7:0];
   assign a0 = st_r.pin_s2[PIN_A0];
   assign idle = (st_r.phase == PH_IDLE);
   assign rd_fall = st_r.rd_d & ~st_r.pin_s2[PIN_RD];
   assign rd_rise = ~st_r.rd_d & st_r.pin_s2[PIN_RD];
   assign wr_rise = ~st_r.wr_d & st_r.pin_s2[PIN_WR];
   // select low is a command, high is RAM data
   assign cmd_wr = wr_rise & ~a0 & idle;
   assign dat_wr = wr_rise & a0 & idle;
   // serial hosts get no RAM read at all
   assign dat_rd = rd_fall & a0 & idle & ~st_r.pin_s2[PIN_SER];
   // status stays readable while busy, so polling works
   assign stat_rd = rd_fall & ~a0;

   // ==========================================================
   // status byte
   always_comb begin
      status = 8'h00;
      status[ST_BUSY] = ~idle;
      status[ST_ADC] = st_r.adc;
      status[ST_OFF] = DISPLAY_OFF;
      status[ST_INIT] = (st_r.phase == PH_INIT);
   end

   // ==========================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      ram_we = 1'b0;
      wr_idx = ram_index(st_r.page, st_r.col);
      rd_idx = wr_idx;
      rd_ok = 1'b0;
      st_nxt.pin_s1 = {HW_RESET_PIN_N, CMD_DATA_SELECT, RD_N, WR_N,
                       SERIAL_SEL, DATA_IN};
      st_nxt.pin_s2 = st_r.pin_s1;
      st_nxt.rd_d = st_r.pin_s2[PIN_RD];
      st_nxt.wr_d = st_r.pin_s2[PIN_WR];
      if (rd_rise) begin
         st_nxt.oe = 1'b0;
      end
      if (st_r.phase != PH_IDLE) begin
         if (st_r.cnt > 16'h0001) begin
            st_nxt.cnt = st_r.cnt - 16'h0001;
         end else begin
            st_nxt.phase = PH_IDLE;
            st_nxt.cnt = 16'h0000;
         end
      end
      if (stat_rd) begin
         st_nxt.dout = status;
         st_nxt.oe = 1'b1;
      end
      if (cmd_wr) begin
         st_nxt.phase = PH_BUSY;
         st_nxt.cnt = 16'(CMD_CYC);
         if (bus_byte == OP_RESET) begin
            // addressing restarts; RAM contents and direction remain
            st_nxt.phase = PH_INIT;
            st_nxt.cnt = 16'(INIT_CYC);
            st_nxt.page = PAGE_RST;
            st_nxt.col = COL_RST;
            st_nxt.rmw = 1'b0;
            st_nxt.dummy = 1'b1;
         end else if (bus_byte == OP_RMW) begin
            st_nxt.rmw = 1'b1;
            st_nxt.col_save = st_r.col;
         end else if (bus_byte == OP_END) begin
            st_nxt.rmw = 1'b0;
            st_nxt.col = st_r.col_save;
            st_nxt.dummy = 1'b1;
         end else if (bus_byte[7:1] == OP_ADC) begin
            st_nxt.adc = bus_byte[0];
         end else if (bus_byte[7:4] == OP_PAGE) begin
            st_nxt.page = bus_byte[3:0];
         end else if (bus_byte[7:4] == OP_COL_HI) begin
            st_nxt.col = {bus_byte[3:0], st_r.col[3:0]};
            st_nxt.dummy = 1'b1;
         end else if (bus_byte[7:4] == OP_COL_LO) begin
            st_nxt.col = {st_r.col[7:4], bus_byte[3:0]};
            st_nxt.dummy = 1'b1;
         end else begin
            // commands handled elsewhere still mark busy
            st_nxt.phase = PH_BUSY;
         end
      end
      if (dat_wr) begin
         ram_we = in_range(st_r.page, st_r.col);
         // read latch is stale after a write
         st_nxt.dummy = 1'b1;
         st_nxt.col = col_inc(st_r.col);
      end
      if (dat_rd) begin
         st_nxt.dout = st_r.latch;
         st_nxt.oe = 1'b1;
         if (st_r.dummy) begin
            // dummy cycle only primes the latch
            st_nxt.dummy = 1'b0;
         end else if (!st_r.rmw) begin
            st_nxt.col = col_inc(st_r.col);
         end
         rd_idx = ram_index(st_r.page, st_nxt.col);
         rd_ok = in_range(st_r.page, st_nxt.col);
         // out-of-range addresses read as zero
         st_nxt.latch = rd_ok ? ram[rd_idx] : 8'h00;
      end
      if (st_r.pin_s2[PIN_RES] == 1'b0) begin
         st_nxt.phase = PH_INIT;
         st_nxt.cnt = 16'(INIT_CYC);
         st_nxt.page = PAGE_RST;
         st_nxt.col = COL_RST;
         st_nxt.rmw = 1'b0;
         st_nxt.adc = ADC_RST;
         st_nxt.dummy = 1'b1;
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         st_r <= '{pin_s1: PIN_IDLE, pin_s2: PIN_IDLE, rd_d: 1'b1,
                   wr_d: 1'b1, phase: PH_INIT, cnt: 16'(INIT_CYC),
                   page: PAGE_RST, col: COL_RST, col_save: COL_RST,
                   rmw: 1'b0, adc: ADC_RST, dummy: 1'b1,
                   latch: 8'h00, dout: 8'h00, oe: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
      if (ram_we) begin
         ram[wr_idx] <= bus_byte;
      end
   end

   assign DATA_OUT = st_r.dout;
   assign DATA_OE = st_r.oe;
   assign SEG_REVERSE = st_r.adc;
   assign PAGE_ADDR = st_r.page;
   assign COLUMN_ADDR = st_r.col;

   // ==========================================================
   // checks
   a_page_load: assert property (
      cmd_wr && bus_byte[7:4] == OP_PAGE && st_r.pin_s2[PIN_RES]
      |=> st_r.page == $past(bus_byte[3:0]))
      else $error("page not loaded from command");

   a_page_status: assert property (
      cmd_wr && bus_byte[7:4] == OP_PAGE && st_r.pin_s2[PIN_RES]
      |=> $stable(st_r.adc) && st_r.phase != PH_INIT)
      else $error("page load disturbed status");

   a_col_upper: assert property (
      cmd_wr && bus_byte[7:4] == OP_COL_HI && st_r.pin_s2[PIN_RES]
      |=> st_r.col == {$past(bus_byte[3:0]), $past(st_r.col[3:0])}
          && st_r.dummy)
      else $error("upper column nibble wrong");

   a_col_step: assert property (
      dat_wr && st_r.col < COL_LAST && st_r.pin_s2[PIN_RES]
      |=> st_r.col == $past(st_r.col) + 8'h01)
      else $error("column did not advance");

   a_col_ceiling: assert property (
      (dat_wr || dat_rd) && st_r.col == COL_LAST && st_r.pin_s2[PIN_RES]
      |=> st_r.col == COL_LAST)
      else $error("column passed its ceiling");

   a_page_keep: assert property (
      (dat_wr || dat_rd) && st_r.pin_s2[PIN_RES] |=> $stable(st_r.page))
      else $error("page changed on data access");

   a_busy_read: assert property (
      stat_rd |=> st_r.dout[ST_BUSY] == ($past(st_r.phase) != PH_IDLE)
                  && st_r.dout[3:0] == 4'h0 && st_r.oe)
      else $error("status byte wrong");

   a_init_flag: assert property (
      !st_r.pin_s2[PIN_RES] ##1 stat_rd |=> st_r.dout[ST_INIT])
      else $error("init bit clear during reset");

   a_dummy_read: assert property (
      dat_rd && st_r.dummy && st_r.pin_s2[PIN_RES]
      |=> $stable(st_r.col) && !st_r.dummy)
      else $error("dummy read moved column");

   a_serial_read: assert property (
      rd_fall && a0 && st_r.pin_s2[PIN_SER] && !st_r.oe |=> !st_r.oe)
      else $error("serial mode drove read data");

   a_rmw_read: assert property (
      dat_rd && st_r.rmw && st_r.pin_s2[PIN_RES] |=> $stable(st_r.col))
      else $error("read moved column in rmw");

   a_cmd_busy: assert property (
      cmd_wr && st_r.pin_s2[PIN_RES] |=> st_r.phase != PH_IDLE)
      else $error("command did not raise busy");

   a_status_bits: assert property (
      stat_rd |=> st_r.dout[ST_ADC] == $past(st_r.adc)
                  && st_r.dout[ST_OFF] == $past(DISPLAY_OFF))
      else $error("direction or display bit wrong");

   a_pin_init: assert property (
      !st_r.pin_s2[PIN_RES]
      |=> st_r.phase == PH_INIT && st_r.col == COL_RST)
      else $error("pin reset did not restart init");

   a_data_store: assert property (
      dat_wr && in_range(st_r.page, st_r.col) && st_r.pin_s2[PIN_RES]
      |=> ram[$past(wr_idx)] == $past(bus_byte))
      else $error("data byte not stored");

   a_read_data: assert property (
      dat_rd && !st_r.dummy && st_r.pin_s2[PIN_RES]
      |=> st_r.dout == $past(st_r.latch) && st_r.oe)
      else $error("read data not from latch");

   a_seg_select: assert property (
      cmd_wr && bus_byte[7:1] == OP_ADC && st_r.pin_s2[PIN_RES]
      |=> st_r.adc == $past(bus_byte[0]))
      else $error("direction not taken from bit 0");

   a_data_path: assert property (
      dat_wr && st_r.pin_s2[PIN_RES] |=> st_r.phase == PH_IDLE)
      else $error("data write taken as command");
endmodule

// [verification/lcd_host_model.sv]
`timescale 1ns/100ps
// ==========================================
// host side of the parallel bus
module lcd_host_model (
   input wire logic clk,
   input wire logic [7:0] din,
   input wire logic oe,
   output logic a0,
   output logic rd_n,
   output logic wr_n,
   output logic [7:0] dout,
   output logic oe_seen
);
   initial begin
      a0 = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      dout = 8'h00;
      oe_seen = 1'b0;
   end
   // strobe 4 clocks, gap 8: above the sync floor, covers busy
   task automatic wr(input logic sel, input logic [7:0] b);
      @(posedge clk);
      a0 <= sel;
      dout <= b;
      wr_n <= 1'b0;
      repeat (4) @(posedge clk);
      wr_n <= 1'b1;
      repeat (4) @(posedge clk);
      dout <= ~b;
      repeat (4) @(posedge clk);
   endtask
   task automatic rd(input logic sel, output logic [7:0] b);
      @(posedge clk);
      a0 <= sel;
      rd_n <= 1'b0;
      repeat (6) @(posedge clk);
      // released bus reads inverted
      b = oe ? din : ~din;
      oe_seen = oe;
      rd_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
   // upper nibble then lower, back to back
   task automatic col(input logic [7:0] c);
      wr(1'b0, {4'h1, c[7:4]});
      wr(1'b0, {4'h0, c[3:0]});
   endtask
endmodule

// [verification/lcd_ram_addressing_commands_tb_top.sv]
`timescale 1ns/100ps
module lcd_ram_addressing_commands_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic pin_n = 1'b1;
   logic ser = 1'b0;
   logic off = 1'b0;
   logic a0, rd_n, wr_n, oe, oe_seen, segment_output;
   logic [7:0] din, dout, col_q, s;
   logic [3:0] pg;
   int mismatches = 0;
   int checks_done = 0;
   always #5 clk = ~clk;
   lcd_ram_addressing_commands u_lcd_ram_addressing_commands (
      .REF_CLK(clk), .RESETN(rst_n),
      .HW_RESET_PIN_N(pin_n), .CMD_DATA_SELECT(a0), .RD_N(rd_n),
      .WR_N(wr_n), .SERIAL_SEL(ser), .DATA_IN(din), .DATA_OUT(dout),
      .DATA_OE(oe), .DISPLAY_OFF(off), .SEG_REVERSE(segment_output),
      .PAGE_ADDR(pg), .COLUMN_ADDR(col_q));
   lcd_host_model u_lcd_host_model (.clk(clk), .din(dout), .oe(oe),
      .a0(a0), .rd_n(rd_n), .wr_n(wr_n), .dout(din), .oe_seen(oe_seen));
   // ==========================================
   // checking and closing
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // bounded poll of the busy bit
   task automatic ready;
      for (int i = 0; i < 20; i++) begin
         u_lcd_host_model.rd(1'b0, s);
         if (s[7] === 1'b0) return;
      end
      mismatches++;
      $display("mismatch at %0t: busy never cleared", $time);
      give_verdict();
   endtask
   // ==========================================
   // tests
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      u_lcd_host_model.rd(1'b0, s);
      check(s, 8'h90);
      ready();
      check(s, 8'h00);
      $display("test reset done");
      u_lcd_host_model.wr(1'b0, 8'hB8);
      check({4'h0, pg}, 8'h08);
      u_lcd_host_model.rd(1'b0, s);
      check(s, 8'h00);
      u_lcd_host_model.wr(1'b0, 8'hB3);
      u_lcd_host_model.col(8'h82);
      check(col_q, 8'h82);
      u_lcd_host_model.wr(1'b1, 8'hAA);
      check(col_q, 8'h83);
      u_lcd_host_model.wr(1'b1, 8'hBB);
      u_lcd_host_model.wr(1'b1, 8'hCC);
      check(col_q, 8'h83);
      check({4'h0, pg}, 8'h03);
      $display("test write done");
      u_lcd_host_model.col(8'h82);
      // first value thrown away
      u_lcd_host_model.rd(1'b1, s);
      check(col_q, 8'h82);
      u_lcd_host_model.rd(1'b1, s);
      check(s, 8'hAA);
      check({7'h0, oe_seen}, 8'h01);
      u_lcd_host_model.rd(1'b1, s);
      check(s, 8'hCC);
      $display("test read done");
      u_lcd_host_model.col(8'h82);
      u_lcd_host_model.wr(1'b0, 8'hE0);
      u_lcd_host_model.rd(1'b1, s);
      u_lcd_host_model.rd(1'b1, s);
      check(col_q, 8'h82);
      u_lcd_host_model.wr(1'b1, 8'h55);
      check(col_q, 8'h83);
      u_lcd_host_model.wr(1'b0, 8'hEE);
      check(col_q, 8'h82);
      $display("test modify done");
      u_lcd_host_model.wr(1'b0, 8'hA1);
      check({7'h0, segment_output}, 8'h01);
      off <= 1'b1;
      u_lcd_host_model.rd(1'b0, s);
      check(s, 8'h60);
      u_lcd_host_model.col(8'h10);
      u_lcd_host_model.wr(1'b1, 8'h01);
      check(col_q, 8'h11);
      ser <= 1'b1;
      u_lcd_host_model.rd(1'b1, s);
      check({7'h0, oe_seen}, 8'h00);
      ser <= 1'b0;
      $display("test direction done");
      u_lcd_host_model.wr(1'b0, 8'hE2);
      u_lcd_host_model.rd(1'b0, s);
      check(s, 8'hF0);
      ready();
      check({pg, 4'h0} | col_q, 8'h00);
      pin_n <= 1'b0;
      repeat (6) @(posedge clk);
      u_lcd_host_model.rd(1'b0, s);
      check(s, 8'hB0);
      pin_n <= 1'b1;
      ready();
      check(s, 8'h20);
      $display("test reset paths done");
      give_verdict();
   end
endmodule
